// ---- include/csad_consts.vh ----
`ifndef CSAD_CONSTS_VH
`define CSAD_CONSTS_VH
// opcode patterns, upper seven bits of the word
`define CSAD_OP_CPGT 7'h32
`define CSAD_OP_CPLT 7'h30
// decrement: upper six bits
`define CSAD_OP_DEC 6'h01
// decimal adjust full word
`define CSAD_OP_DAW 16'h0007
`define CSAD_NOP_WORD 16'h0000
// field positions
`define CSAD_BIT_A 8
`define CSAD_BIT_D 9
// status flag positions
`define CSAD_FLAG_C 0
`define CSAD_FLAG_DC 1
`define CSAD_FLAG_Z 2
`define CSAD_FLAG_OV 3
`define CSAD_FLAG_N 4
// reset values
`define CSAD_RST_WORK 8'h00
`define CSAD_RST_STATUS 5'h00
`define CSAD_RST_BANK 4'h0
// quarter phases, one-hot
`define CSAD_Q1 4'h1
`define CSAD_Q2 4'h2
`define CSAD_Q3 4'h4
`define CSAD_Q4 4'h8
`endif

// ---- hdl/csad_exec.v ----
`timescale 1ns/1ps
`include "csad_consts.vh"

// How it works
// [RQ1] a word whose top seven bits are 0110010 is compare_skip_greater, bit 8 the bank select, low byte the address.
// [RQ2] compare_skip_greater skips the fetched next instruction when the file value exceeds working_register.
// [RQ3] both compares subtract working_register from the file value unsigned and leave every flag untouched.
// [RQ4] top seven bits 0110000 is compare_skip_less, which skips when the file value is below working_register.
// [RQ5] bank bit zero addresses the access bank, bank bit one lets bank_select_register pick the bank.
// [RQ6] a compare is one word, one cycle without skip and two cycles when skipping a one-word instruction.
// [RQ7] skipping a two-word instruction costs three cycles, two whole no-operation cycles after the compare.
// [RQ8] a compare decodes in q1, reads in q2, processes in q3 and writes nothing in q4.
// [RQ9] decrement_file subtracts one from the file value, reads in q2 and writes the destination in q4; file_wr_o is raised in the next q1.
// [RQ10] decrement destination bit zero writes working_register, one writes back to the file register.
// [RQ11] decimal_adjust_working adds six per nibble when above nine or its carry is set, updating carry.
// [RQ12] decrement sets c, dc, n, ov and z from its result; decimal adjust is one cycle touching only working_register and the carry flag.
module csad_exec (
  input wire clk_i,
  input wire rstn_i,
  input wire [15:0] instr_i,
  input wire instr_valid_i,
  input wire next_two_word_i,
  input wire [3:0] bank_select_register_i,
  input wire [7:0] file_rdata_i,
  output reg [11:0] file_addr_o,
  output reg file_rd_o,
  output reg file_wr_o,
  output reg [7:0] file_wdata_o,
  output reg [7:0] working_register_o,
  output reg [4:0] status_o,
  output reg [3:0] quarter_o,
  output reg skip_o,
  output reg busy_o
);

  // sequencer states, one-hot
  localparam ST_EXEC = 3'b001;
  localparam ST_NOP1 = 3'b010;
  localparam ST_NOP2 = 3'b100;

  // bit positions of the decoded instruction kind
  localparam KB_GT = 0;
  localparam KB_LT = 1;
  localparam KB_DEC = 2;
  localparam KB_DAW = 3;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [15:0] ir;
  reg [7:0] fval;
  reg [7:0] next_work;
  reg [4:0] next_status;
  reg skip_now;
  reg two_word;

  // one decoder serves both the fetched word and the held word
  function [3:0] op_kind;
    input [15:0] w;
    begin
      op_kind = 4'h0;
      if (w[15:9] == `CSAD_OP_CPGT) begin
        op_kind[KB_GT] = 1'b1;
      end
      if (w[15:9] == `CSAD_OP_CPLT) begin
        op_kind[KB_LT] = 1'b1;
      end
      if (w[15:10] == `CSAD_OP_DEC) begin
        op_kind[KB_DEC] = 1'b1;
      end
      if (w == `CSAD_OP_DAW) begin
        op_kind[KB_DAW] = 1'b1;
      end
    end
  endfunction

  wire [3:0] ir_kind = op_kind(ir);
  wire [3:0] in_kind = op_kind(instr_i);

  wire is_gt = ir_kind[KB_GT]; // see [RQ1]
  wire is_lt = ir_kind[KB_LT]; // see [RQ4]
  wire is_dec = ir_kind[KB_DEC];
  wire is_daw = ir_kind[KB_DAW];
  wire is_cmp = is_gt | is_lt;

  // decimal adjust never asks for a file read
  wire in_reads = instr_valid_i & (in_kind[KB_GT] | in_kind[KB_LT] | in_kind[KB_DEC]); // see [RQ8] [RQ9] [RQ12]

  wire in_q1 = (quarter_o == `CSAD_Q1);
  wire in_q2 = (quarter_o == `CSAD_Q2);
  wire in_q3 = (quarter_o == `CSAD_Q3);
  wire in_q4 = (quarter_o == `CSAD_Q4);
  wire executing = (state == ST_EXEC);

  // access bank: low half from bank 0, high half from bank 15
  function [11:0] eff_addr;
    input a_bit;
    input [7:0] f;
    input [3:0] bank_select_register;
    begin
      if (a_bit)
        eff_addr = {bank_select_register, f}; // see [RQ5]
      else if (f[7])
        eff_addr = {4'hF, f}; // see [RQ5]
      else
        eff_addr = {4'h0, f};
    end
  endfunction

  // decrement result as f + 0xff so carry means no borrow
  wire [8:0] dec_sum = {1'b0, fval} + 9'h0FF; // see [RQ9]
  wire [4:0] dec_low = {1'b0, fval[3:0]} + 5'h0F;
  wire [7:0] dec_res = dec_sum[7:0];

  // daw stages
  wire lo_adj = (working_register_o[3:0] > 4'h9) | status_o[`CSAD_FLAG_DC];
  wire [8:0] daw_a = {1'b0, working_register_o} + (lo_adj ? 9'h006 : 9'h000);
  wire hi_adj = (daw_a[7:4] > 4'h9) | status_o[`CSAD_FLAG_C] | daw_a[8];
  wire [8:0] daw_b = daw_a + (hi_adj ? 9'h060 : 9'h000);

  wire wr_back = is_dec & ir[`CSAD_BIT_D];

  always @* begin
    next_work = working_register_o;
    next_status = status_o;
    skip_now = 1'b0;
    if (is_gt)
      skip_now = (fval > working_register_o); // see [RQ2] [RQ3]
    else if (is_lt)
      skip_now = (fval < working_register_o); // see [RQ3] [RQ4]
    if (is_dec) begin
      if (!ir[`CSAD_BIT_D])
        next_work = dec_res; // see [RQ10]
      next_status[`CSAD_FLAG_C] = dec_sum[8]; // see [RQ12]
      next_status[`CSAD_FLAG_DC] = dec_low[4];
      next_status[`CSAD_FLAG_N] = dec_res[7];
      next_status[`CSAD_FLAG_Z] = (dec_res == 8'h00);
      next_status[`CSAD_FLAG_OV] = (fval == 8'h80);
    end
    if (is_daw) begin
      next_work = daw_b[7:0]; // see [RQ11] [RQ12]
      next_status[`CSAD_FLAG_C] = hi_adj | daw_b[8];
    end
  end

  // skip sequencer, only moves at the end of an instruction cycle
  always @* begin
    next_state = state;
    case (state)
      ST_EXEC: begin
        if (is_cmp && skip_now) begin
          next_state = ST_NOP1; // see [RQ2] [RQ6]
        end
      end
      ST_NOP1: begin
        if (two_word) begin
          next_state = ST_NOP2; // see [RQ7]
        end else begin
          next_state = ST_EXEC; // see [RQ6]
        end
      end
      ST_NOP2: begin
        next_state = ST_EXEC; // see [RQ7]
      end
      default: begin
        next_state = ST_EXEC;
      end
    endcase
  end

  // quarter phase ring; a corrupted ring falls back to q1
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      quarter_o <= `CSAD_Q1;
    end else if (in_q1 | in_q2 | in_q3 | in_q4) begin
      quarter_o <= {quarter_o[2:0], quarter_o[3]};
    end else begin
      quarter_o <= `CSAD_Q1;
    end
  end

  // decode; a skipped slot runs as a no-operation
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      ir <= `CSAD_NOP_WORD;
    end else if (in_q1) begin
      if (executing && instr_valid_i) begin
        ir <= instr_i; // see [RQ8]
      end else begin
        ir <= `CSAD_NOP_WORD; // see [RQ2]
      end
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      file_addr_o <= 12'h000;
    end else if (in_q1 && executing) begin
      file_addr_o <= eff_addr(instr_i[`CSAD_BIT_A], instr_i[7:0], bank_select_register_i); // see [RQ5]
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      file_rd_o <= 1'b0;
    end else begin
      file_rd_o <= in_q1 & executing & in_reads; // see [RQ8] [RQ9]
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      fval <= 8'h00;
    end else if (in_q2) begin
      fval <= file_rdata_i; // see [RQ8]
    end
  end

  // only the compare cycle says what follows it; nop cycles must not resample
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      two_word <= 1'b0;
    end else if (in_q3 && executing) begin
      two_word <= next_two_word_i; // see [RQ7]
    end
  end

  // compares leave both untouched since next_* equal the current values
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      working_register_o <= `CSAD_RST_WORK;
      status_o <= `CSAD_RST_STATUS;
    end else if (in_q4) begin
      working_register_o <= next_work; // see [RQ10] [RQ11]
      status_o <= next_status; // see [RQ3] [RQ12]
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      file_wr_o <= 1'b0;
    end else begin
      file_wr_o <= in_q4 & wr_back; // see [RQ8] [RQ9] [RQ10]
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      file_wdata_o <= 8'h00;
    end else if (in_q4 && wr_back) begin
      file_wdata_o <= dec_res; // see [RQ9]
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      skip_o <= 1'b0;
    end else begin
      skip_o <= in_q4 & executing & is_cmp & skip_now; // see [RQ2] [RQ4]
    end
  end

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      state <= ST_EXEC;
    end else if (in_q4) begin
      state <= next_state;
    end
  end

  // busy tracks the state register so it covers every inserted cycle
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      busy_o <= 1'b0;
    end else if (in_q4) begin
      busy_o <= (next_state != ST_EXEC); // see [RQ6] [RQ7]
    end
  end

endmodule // csad_exec

// ---- tb/csad_exec_asserts.sv ----
`timescale 1ns/1ps
`include "csad_consts.vh"
module csad_exec_asserts (
  input wire clk_i,
  input wire rstn_i,
  input wire instr_valid_i,
  input wire file_rd_o,
  input wire file_wr_o,
  input wire skip_o,
  input wire busy_o,
  input wire [15:0] instr_i,
  input wire [3:0] bank_select_register_i,
  input wire [3:0] quarter_o,
  input wire [7:0] file_rdata_i,
  input wire [7:0] file_wdata_o,
  input wire [11:0] file_addr_o,
  input wire [4:0] status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // compare taken on this edge; nop cycles refuse it
  wire cmp = quarter_o == `CSAD_Q1 && !busy_o && !skip_o && instr_valid_i
    && (instr_i[15:9] == `CSAD_OP_CPGT || instr_i[15:9] == `CSAD_OP_CPLT);
  a_quarter_onehot: assert property ($onehot(quarter_o)) else $error("phase not one-hot");
  a_quarter_wrap: assert property (quarter_o == `CSAD_Q4 |=> quarter_o == `CSAD_Q1)
    else $error("phase did not wrap");
  a_read_in_q2: assert property (file_rd_o |-> quarter_o == `CSAD_Q2) else $error("read off q2");
  a_bank_select: assert property (file_rd_o |-> file_addr_o == {($past(instr_i[8]) ?
    $past(bank_select_register_i) : {4{$past(instr_i[7])}}), $past(instr_i[7:0])}) else $error("bad address");
  a_dec_wdata: assert property (file_wr_o |-> file_wdata_o == $past(file_rdata_i, 3) - 8'h01)
    else $error("bad write data");
  a_cmp_flags: assert property (cmp |=> $stable(status_o)[*4]) else $error("compare moved flags");
  a_skip_busy: assert property (skip_o |-> ##[0:1] busy_o) else $error("skip without nop");
  a_busy_span: assert property ($rose(busy_o) |-> busy_o[*4] ##1 (!busy_o or busy_o[*4] ##1 !busy_o))
    else $error("nop span wrong");
  a_quiet_nops: assert property (busy_o |-> !file_rd_o && !file_wr_o) else $error("access in nop");
  cover property (skip_o);
  cover property (busy_o[*8]);
  cover property (file_wr_o);
endmodule // csad_exec_asserts
bind csad_exec csad_exec_asserts u_csad_exec_asserts (.*);

// ---- tb/csad_exec_test.sv ----
`timescale 1ns/1ps
module csad_exec_test;
  logic clk_i = 0, rstn_i = 0, instr_valid_i = 0, next_two_word_i = 0;
  logic [15:0] instr_i = 0;
  logic [3:0] bank_select_register_i = 0;
  logic [7:0] file_rdata_i = 0, n_skip = 0, n_busy = 0, n_wr = 0, wr_val = 0;
  wire file_rd_o, file_wr_o, skip_o, busy_o;
  wire [11:0] file_addr_o;
  wire [7:0] file_wdata_o, working_register_o;
  wire [4:0] status_o;
  wire [3:0] quarter_o;
  int n_errors = 0, n_checks = 0;
  always #12.5 clk_i = ~clk_i;
  csad_exec u_csad_exec (.*);
  // pulses are too short to catch at the end of a step, so count them here
  always @(posedge clk_i) if (rstn_i) begin
    n_skip <= n_skip + {7'h00, skip_o};
    n_busy <= n_busy + {7'h00, busy_o};
    n_wr <= n_wr + {7'h00, file_wr_o};
    if (file_wr_o) wr_val <= file_wdata_o;
  end
  task chk(input string nm, input [7:0] got, input [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // n is the instruction cycles the word should cost; the word stays offered meanwhile
  task exec(input [15:0] w, input [7:0] fv, input tw, input [2:0] n, input [7:0] ew, input [4:0] est);
    logic [7:0] s0, b0, w0;
    s0 = n_skip;
    b0 = n_busy;
    w0 = n_wr;
    instr_i <= w;
    file_rdata_i <= fv;
    next_two_word_i <= tw;
    bank_select_register_i <= w[3:0];
    instr_valid_i <= 1'b1;
    repeat (4 * n) @(posedge clk_i);
    instr_valid_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("skips", n_skip - s0, {7'h00, n > 3'd1});
    chk("nop cycles", n_busy - b0, {3'h0, n - 3'd1, 2'b00});
    chk("working", working_register_o, ew);
    chk("status", {3'h0, status_o}, {3'h0, est});
    chk("writes", n_wr - w0, {7'h00, w[15:9] == 7'h03});
    if (w[15:9] == 7'h03) chk("write data", wr_val, fv - 8'h01);
  endtask
  task t_decrement;
    exec(16'h0420, 8'h80, 1'b0, 3'd1, 8'h7f, 5'h09);
    exec(16'h0791, 8'h01, 1'b0, 3'd1, 8'h7f, 5'h07);
    $display("decrement test done");
  endtask
  task t_greater;
    exec(16'h6410, 8'h80, 1'b0, 3'd2, 8'h7f, 5'h07);
    exec(16'h6510, 8'h7f, 1'b0, 3'd1, 8'h7f, 5'h07);
    $display("greater test done");
  endtask
  task t_less;
    exec(16'h6133, 8'h00, 1'b1, 3'd3, 8'h7f, 5'h07);
    exec(16'h6033, 8'hff, 1'b0, 3'd1, 8'h7f, 5'h07);
    $display("less test done");
  endtask
  task t_adjust;
    exec(16'h04a6, 8'ha6, 1'b0, 3'd1, 8'ha5, 5'h13);
    exec(16'h0007, 8'h00, 1'b0, 3'd1, 8'h0b, 5'h13);
    $display("adjust test done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_decrement;
    t_greater;
    t_less;
    t_adjust;
    tally_and_finish;
  end
endmodule // csad_exec_test
